// *** src/flash_cmd_decode.sv ***
/*
 serial command decoder with soft reset and continuous read escape.
 assumes a host driving select and clock in mode 0 or 3, and that
 the system clock runs several times faster than the serial clock.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_decode import flash_cmd_pkg::*; #(
	parameter int recovery_cycles = reset_recovery_cycles
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic select_n_in,
	input wire logic serial_clk_in,
	input wire logic [3:0] data_line_in,
	input wire logic cont_read_enter_in,
	input wire logic [7:0] status_wr_in,
	input wire logic [7:0] config_wr_in,
	input wire logic [7:0] training_wr_in,
	input wire logic regs_wr_in,
	input wire logic sector_guard_set_in,
	output logic [7:0] status_out,
	output logic [7:0] config_out,
	output logic [7:0] training_out,
	output logic sector_guard_latch_out,
	output logic cont_read_out,
	output logic busy_out,
	output logic cmd_valid_out,
	output logic [4:0] cmd_kind_out,
	output logic cmd_wide_addr_out,
	output logic [7:0] cmd_max_mhz_out,
	output logic nv_training_prog_out
);
	initial begin
		if (recovery_cycles < 1)
			$error("recovery_cycles must be at least one");
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	logic sck_prev_ff;
	logic cs_prev_ff;
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_ff <= 6'h03;
			sync2_ff <= 6'h03;
			sck_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b1;
		end else begin
			sync1_ff <= {data_line_in, serial_clk_in, select_n_in};
			sync2_ff <= sync1_ff;
			sck_prev_ff <= sync2_ff[1];
			cs_prev_ff <= sync2_ff[0];
		end
	end
	logic cs_n;
	logic sck_rise;
	logic cs_rise;
	logic line0;
	assign cs_n = sync2_ff[0];
	assign line0 = sync2_ff[2];
	// sampling on rising serial edges only; other lines are ignored here
	assign sck_rise = sync2_ff[1] && !sck_prev_ff && !cs_n;
	assign cs_rise = cs_n && !cs_prev_ff;

	// ****************************************
	// opcode decode
	// ****************************************
	function automatic cmd_decode_t decode(input logic [7:0] op);
		cmd_decode_t d;
		d = '{kind: op_none, wide_addr_only: 1'b0, max_mhz: 8'd133};
		unique case (op)
			write_status_config_cmd: d.kind = op_write_regs; // [R10]
			read_status_one_cmd: d.kind = op_read_status; // [R10]
			read_config_one_cmd: d.kind = op_read_config; // [R10]
			plain_read_cmd: begin
				d.kind = op_plain_read; // [R11]
				d.max_mhz = 8'd50;
			end
			plain_read_wide_addr_cmd: begin
				d.kind = op_plain_read; // [R11]
				d.wide_addr_only = 1'b1;
				d.max_mhz = 8'd50;
			end
			quick_read_cmd: d.kind = op_quick_read; // [R12]
			quick_read_wide_addr_cmd: begin
				d.kind = op_quick_read; // [R12]
				d.wide_addr_only = 1'b1;
			end
			double_rate_quick_read_cmd: begin
				d.kind = op_double_rate_read; // [R13]
				d.max_mhz = 8'd80;
			end
			double_rate_quick_read_wide_cmd: begin
				d.kind = op_double_rate_read; // [R13]
				d.wide_addr_only = 1'b1;
				d.max_mhz = 8'd80;
			end
			two_line_out_read_cmd: begin
				d.kind = op_two_line_read; // [R14]
				d.max_mhz = 8'd104;
			end
			two_line_out_read_wide_cmd: begin
				d.kind = op_two_line_read; // [R14]
				d.wide_addr_only = 1'b1;
				d.max_mhz = 8'd104;
			end
			four_line_out_read_cmd: begin
				d.kind = op_four_line_read; // [R15]
				d.max_mhz = 8'd104;
			end
			page_write_cmd: d.kind = op_page_write; // [R16]
			page_write_wide_addr_cmd: begin
				d.kind = op_page_write; // [R16]
				d.wide_addr_only = 1'b1;
			end
			four_line_page_write_cmd, four_line_page_write_alt_cmd: begin
				d.kind = op_four_line_page_write; // [R17]
				d.max_mhz = 8'd80;
			end
			small_sector_erase_cmd: d.kind = op_small_erase; // [R18]
			small_sector_erase_wide_cmd: begin
				d.kind = op_small_erase; // [R18]
				d.wide_addr_only = 1'b1;
			end
			status_clear_cmd: d.kind = op_status_clear; // [R19]
			volatile_training_write_cmd: d.kind = op_training_write; // [R20]
			nv_training_program_cmd: d.kind = op_training_program; // [R21]
			training_pattern_read_cmd: d.kind = op_training_read; // [R21]
			soft_reset_cmd: d.kind = op_soft_reset; // [R1]
			continuous_read_escape_cmd: d.kind = op_escape; // [R7]
			reserved_e5_cmd, reserved_e6_cmd: begin
				d.kind = op_reserved; // [R22]
				d.max_mhz = 8'h00;
			end
			default: begin
				d.kind = op_none; // [R23]
				d.max_mhz = 8'h00;
			end
		endcase
		return d;
	endfunction

	// ****************************************
	// link state machine
	// ****************************************
	link_state_t state_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	cmd_decode_t cmd_ff;
	logic [31:0] recover_cnt_ff;
	logic [7:0] next_shift;
	logic byte_done;
	cmd_decode_t cur;
	assign next_shift = {shift_ff[6:0], line0};
	assign byte_done = sck_rise && (bit_cnt_ff == 3'h7);
	assign cur = decode(next_shift);

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= st_idle;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			cmd_ff <= '{kind: op_none, wide_addr_only: 1'b0, max_mhz: 8'h00};
			recover_cnt_ff <= 32'h0;
		end else begin
			unique case (state_ff)
				st_idle: begin
					bit_cnt_ff <= 3'h0;
					if (!cs_n)
						state_ff <= st_opcode;
				end
				st_opcode: begin
					if (cs_rise) begin
						state_ff <= st_idle;
					end else if (sck_rise) begin
						shift_ff <= next_shift;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (byte_done) begin
							cmd_ff <= cur;
							state_ff <= st_body;
						end
					end
				end
				st_body: begin
					// unknown opcodes just wait here for select high
					if (cs_rise) begin // [R23]
						if (cmd_ff.kind == op_soft_reset) begin
							state_ff <= st_recover; // [R6]
							recover_cnt_ff <= 32'(recovery_cycles - 1);
						end else begin
							state_ff <= st_idle;
						end
					end
				end
				st_recover: begin
					// commands during recovery are dropped
					if (recover_cnt_ff == 32'h0)
						state_ff <= st_idle; // [R6]
					else
						recover_cnt_ff <= recover_cnt_ff - 32'h1;
				end
			endcase
		end
	end

	logic exec_at_cs;
	logic do_soft_reset;
	assign exec_at_cs = (state_ff == st_body) && cs_rise;
	assign do_soft_reset = exec_at_cs && (cmd_ff.kind == op_soft_reset);
	// escape is recognised the moment its byte is in, but only as the opcode byte of a frame
	logic do_escape;
	assign do_escape = byte_done && (state_ff == st_opcode) &&
		(cur.kind == op_escape); // [R7]

	// ****************************************
	// registers and soft reset
	// ****************************************
	logic [7:0] status_ff;
	logic [7:0] config_ff;
	logic [7:0] training_ff;
	logic guard_ff;
	logic cont_read_ff;
	logic nv_prog_ff;
	logic frozen;
	assign frozen = config_ff[cr_freeze_pos];

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_ff <= status_reset_value;
			config_ff <= config_reset_value;
		end else if (do_soft_reset) begin
			status_ff[sr_prog_fail_pos] <= 1'b0; // [R1]
			status_ff[sr_erase_fail_pos] <= 1'b0; // [R1]
			status_ff[1:0] <= 2'b00; // [R1]
			status_ff[7] <= 1'b0;
			if (config_ff[cr_bp_vol_pos] && !frozen)
				status_ff[sr_bp2_pos:sr_bp0_pos] <= 3'h0; // [R4]
			// only the volatile bits that freeze does not guard
			if (!frozen) begin // [R5]
				config_ff[0] <= 1'b0;
				config_ff[7:6] <= 2'b00;
				config_ff[4] <= 1'b0;
			end
			// freeze, top/bottom, param location, volatility kept
			config_ff[cr_freeze_pos] <= config_ff[cr_freeze_pos]; // [R2]
			config_ff[cr_top_bottom_pos] <= config_ff[cr_top_bottom_pos]; // [R3]
		end else if (exec_at_cs && cmd_ff.kind == op_status_clear) begin
			status_ff[sr_prog_fail_pos] <= 1'b0; // [R19]
			status_ff[sr_erase_fail_pos] <= 1'b0; // [R19]
			status_ff[1:0] <= 2'b00; // [R19]
		end else if (regs_wr_in) begin
			status_ff <= status_wr_in;
			// freeze stays set once set
			config_ff <= config_wr_in | (config_ff & 8'h02);
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			guard_ff <= 1'b1;
		else if (sector_guard_set_in)
			guard_ff <= 1'b1;
		// soft reset leaves the guard latch alone
		else
			guard_ff <= guard_ff; // [R2]
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			training_ff <= training_reset_value;
		else if (do_soft_reset)
			training_ff <= training_reset_value; // [R1]
		else if (regs_wr_in && cmd_ff.kind == op_training_write)
			training_ff <= training_wr_in; // [R20]
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			nv_prog_ff <= 1'b0;
		else
			nv_prog_ff <= exec_at_cs &&
				cmd_ff.kind == op_training_program; // [R21]
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			cont_read_ff <= 1'b0;
		else if (do_escape || do_soft_reset)
			cont_read_ff <= 1'b0; // [R7]
		else if (cont_read_enter_in)
			cont_read_ff <= 1'b1;
	end

	// ****************************************
	// outputs
	// ****************************************
	logic valid_ff;
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			valid_ff <= 1'b0;
		else
			valid_ff <= byte_done && (state_ff == st_opcode) &&
				(cur.kind != op_none) && (cur.kind != op_reserved);
	end

	assign status_out = status_ff;
	assign config_out = config_ff;
	assign training_out = training_ff;
	assign sector_guard_latch_out = guard_ff;
	assign cont_read_out = cont_read_ff;
	assign busy_out = (state_ff == st_recover);
	assign cmd_valid_out = valid_ff;
	assign cmd_kind_out = cmd_ff.kind;
	assign cmd_wide_addr_out = cmd_ff.wide_addr_only;
	assign cmd_max_mhz_out = cmd_ff.max_mhz;
	assign nv_training_prog_out = nv_prog_ff;
endmodule
`default_nettype wire

// *** src/flash_cmd_pkg.sv ***
/*
 the constants, opcode map, types and timing counts of the command decoder.
 assumes a 250 MHz system clock that samples the serial link.
*/
//
// Function
// [R1] reset opcode restores power-up state, two exceptions
// [R2] freeze and guard latch survive soft reset
// [R3] nonvolatile config select bits survive soft reset
// [R4] block protect cleared only volatile and unfrozen
// [R5] soft reset never unlocks guarded security bits
// [R6] reset starts at select high, needs recovery
// [R7] escape opcode leaves continuous read mode
// [R8] host sends ones on line0 eight clocks
// [R9] host sends escape before soft reset
// [R10] register write and status/config read opcodes
// [R11] plain read opcodes, host clock 50 MHz
// [R12] quick read opcodes up to 133 MHz
// [R13] double rate quick read opcodes, 80 MHz
// [R14] two-line output reads up to 104 MHz
// [R15] four-line output read up to 104 MHz
// [R16] page write opcodes, both address forms
// [R17] four-line page write opcodes, 80 MHz
// [R18] small sector erase opcodes
// [R19] status clear opcode clears failure flags
// [R20] volatile training register write opcode
// [R21] nonvolatile training program and pattern read
// [R22] opcodes e5 and e6 are reserved
// [R23] unknown opcode ignored until select high
// [R24] host keeps clock within command maximum
package flash_cmd_pkg;
	localparam logic [7:0] write_status_config_cmd = 8'h01;
	localparam logic [7:0] page_write_cmd = 8'h02;
	localparam logic [7:0] plain_read_cmd = 8'h03;
	localparam logic [7:0] read_status_one_cmd = 8'h05;
	localparam logic [7:0] quick_read_cmd = 8'h0b;
	localparam logic [7:0] quick_read_wide_addr_cmd = 8'h0c;
	localparam logic [7:0] double_rate_quick_read_cmd = 8'h0d;
	localparam logic [7:0] double_rate_quick_read_wide_cmd = 8'h0e;
	localparam logic [7:0] page_write_wide_addr_cmd = 8'h12;
	localparam logic [7:0] plain_read_wide_addr_cmd = 8'h13;
	localparam logic [7:0] small_sector_erase_cmd = 8'h20;
	localparam logic [7:0] small_sector_erase_wide_cmd = 8'h21;
	localparam logic [7:0] status_clear_cmd = 8'h30;
	localparam logic [7:0] four_line_page_write_cmd = 8'h32;
	localparam logic [7:0] read_config_one_cmd = 8'h35;
	localparam logic [7:0] four_line_page_write_alt_cmd = 8'h38;
	localparam logic [7:0] two_line_out_read_cmd = 8'h3b;
	localparam logic [7:0] two_line_out_read_wide_cmd = 8'h3c;
	localparam logic [7:0] training_pattern_read_cmd = 8'h41;
	localparam logic [7:0] nv_training_program_cmd = 8'h43;
	localparam logic [7:0] volatile_training_write_cmd = 8'h4a;
	localparam logic [7:0] four_line_out_read_cmd = 8'h6b;
	localparam logic [7:0] reserved_e5_cmd = 8'he5;
	localparam logic [7:0] reserved_e6_cmd = 8'he6;
	localparam logic [7:0] soft_reset_cmd = 8'hf0;
	localparam logic [7:0] continuous_read_escape_cmd = 8'hff;

	// status register one field positions
	localparam int sr_bp0_pos = 2;
	localparam int sr_bp2_pos = 4;
	localparam int sr_erase_fail_pos = 5;
	localparam int sr_prog_fail_pos = 6;
	// config register one field positions
	localparam int cr_freeze_pos = 1;
	localparam int cr_param_loc_pos = 2;
	localparam int cr_bp_vol_pos = 3;
	localparam int cr_top_bottom_pos = 5;
	localparam logic [7:0] status_reset_value = 8'h00;
	localparam logic [7:0] config_reset_value = 8'h00;
	localparam logic [7:0] training_reset_value = 8'h00;

	localparam int sys_clk_mhz = 250;
	localparam int reset_recovery_time_ns = 35000;
	localparam int reset_recovery_cycles =
		(reset_recovery_time_ns * sys_clk_mhz + 999) / 1000;

	typedef enum logic [4:0] {
		op_none, op_write_regs, op_read_status, op_read_config,
		op_plain_read, op_quick_read, op_double_rate_read,
		op_two_line_read, op_four_line_read, op_page_write,
		op_four_line_page_write, op_small_erase, op_status_clear,
		op_training_write, op_training_program, op_training_read,
		op_soft_reset, op_escape, op_reserved
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t kind;
		logic wide_addr_only;
		logic [7:0] max_mhz;
	} cmd_decode_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_opcode = 2'b01,
		st_body = 2'b11,
		st_recover = 2'b10
	} link_state_t;
endpackage

// *** dv/flash_cmd_decode_monitor.sv ***
/*
 output checks of the serial command decoder.
 assumes a bind to every flash_cmd_decode instance.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_decode_monitor import flash_cmd_pkg::*; #(
	parameter int recovery_cycles = 20
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] status_out,
	input wire logic [7:0] config_out,
	input wire logic sector_guard_latch_out,
	input wire logic cont_read_out,
	input wire logic busy_out,
	input wire logic cmd_valid_out,
	input wire logic [4:0] cmd_kind_out,
	input wire logic [7:0] cmd_max_mhz_out
);
	// ****************
	// checks
	// ****************
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	logic [15:0] busy_cnt_ff;
	// counter, since a repetition cannot span the recovery time
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_cnt_ff <= 16'h0000;
		end else begin
			busy_cnt_ff <= busy_out ? busy_cnt_ff + 16'h0001 : 16'h0000;
		end
	end
	busy_span_a: assert property ($fell(busy_out) |->
		busy_cnt_ff == 16'(recovery_cycles)) else $error("recovery length");
	busy_quiet_a: assert property (busy_out |-> !cmd_valid_out)
		else $error("command taken while recovering");
	guard_keep_a: assert property ($rose(busy_out) |->
		$stable(sector_guard_latch_out)) else $error("guard latch moved");
	config_keep_a: assert property ($rose(busy_out) |->
		(config_out & 8'h2e) == ($past(config_out) & 8'h2e))
		else $error("kept config bits changed");
	protect_rule_a: assert property ($rose(busy_out) |->
		(status_out & 8'h1c) == (($past(config_out) & 8'h0a) == 8'h08 ?
		8'h00 : ($past(status_out) & 8'h1c))) else $error("block protect");
	fail_clear_a: assert property ($rose(busy_out) |->
		(status_out & 8'h60) == 8'h00 && !cont_read_out)
		else $error("soft reset left state");
	escape_exit_a: assert property (cmd_valid_out &&
		cmd_kind_out == op_escape |-> ##[0:2] !cont_read_out)
		else $error("continuous read kept");
	read_rate_a: assert property (cmd_valid_out &&
		cmd_kind_out == op_plain_read |-> cmd_max_mhz_out == 8'h32)
		else $error("plain read rate");
	slow_rate_a: assert property (cmd_valid_out &&
		cmd_kind_out inside {op_double_rate_read, op_four_line_page_write}
		|-> cmd_max_mhz_out == 8'h50) else $error("80 MHz rate");
	multi_rate_a: assert property (cmd_valid_out &&
		cmd_kind_out inside {op_two_line_read, op_four_line_read}
		|-> cmd_max_mhz_out == 8'h68) else $error("multi line rate");
	valid_kind_a: assert property (cmd_valid_out |->
		!(cmd_kind_out inside {op_none, op_reserved}))
		else $error("valid on undefined opcode");
endmodule
bind flash_cmd_decode flash_cmd_decode_monitor #(
	.recovery_cycles(recovery_cycles)) u_monitor (.sys_clk_in, .resetn_in,
	.status_out, .config_out, .sector_guard_latch_out, .cont_read_out,
	.busy_out, .cmd_valid_out, .cmd_kind_out, .cmd_max_mhz_out);
`default_nettype wire

// *** dv/spi_host_model.sv ***
/*
 serial host that frames one opcode per select-low period.
 assumes the bench calls frame and waits for it to return.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	output logic select_n_out,
	output logic sclk_out,
	output logic [3:0] data_out
);
	// ****************
	// host
	// ****************
	localparam int half_ns = 80;
	initial begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		data_out = 4'ha;
	end
	// clock idles low; released lines show the inverse of the last value
	task automatic frame(input logic [7:0] op);
		#(half_ns + 7);
		select_n_out = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			data_out = {3'($urandom), op[i]};
			#half_ns sclk_out = 1'b1;
			#half_ns sclk_out = 1'b0;
		end
		#half_ns select_n_out = 1'b1;
		data_out = ~data_out;
	endtask
endmodule
`default_nettype wire

// *** dv/spi_flash_reset_and_opcode_decode_test.sv ***
/*
 self-checking bench of the serial command decoder.
 assumes the host model on the link and the bound monitor.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_flash_reset_and_opcode_decode_test import flash_cmd_pkg::*;;
	logic sys_clk = 1'b0, resetn = 1'b0, enter = 1'b0, regs_wr = 1'b0;
	logic guard_set = 1'b0, sel_n, sclk, cont, busy, valid, wide, nvp, guard;
	logic [7:0] st_wr = 8'h00, cf_wr = 8'h00, tr_wr = 8'h00, st, cf, tr, mx;
	logic [3:0] dl;
	logic [4:0] kind;
	logic [13:0] got;
	logic frozen = 1'b0;
	int n_fail = 0, compares = 0, n_valid = 0, n_nvp = 0;
	logic [7:0] ops[26] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h0b, 8'h0c, 8'h0d,
		8'h0e, 8'h12, 8'h13, 8'h20, 8'h21, 8'h30, 8'h32, 8'h35, 8'h38, 8'h3b,
		8'h3c, 8'h41, 8'h43, 8'h4a, 8'h6b, 8'hf0, 8'hff, 8'he5, 8'he6};
	spi_host_model u_host (.select_n_out(sel_n), .sclk_out(sclk),
		.data_out(dl));
	flash_cmd_decode #(.recovery_cycles(500)) i_dut (.sys_clk_in(sys_clk),
		.resetn_in(resetn), .select_n_in(sel_n), .serial_clk_in(sclk),
		.data_line_in(dl), .cont_read_enter_in(enter), .status_wr_in(st_wr),
		.config_wr_in(cf_wr), .training_wr_in(tr_wr), .regs_wr_in(regs_wr),
		.sector_guard_set_in(guard_set), .status_out(st), .config_out(cf),
		.training_out(tr), .sector_guard_latch_out(guard),
		.cont_read_out(cont), .busy_out(busy), .cmd_valid_out(valid),
		.cmd_kind_out(kind), .cmd_wide_addr_out(wide), .cmd_max_mhz_out(mx),
		.nv_training_prog_out(nvp));
	// ****************
	// helpers
	// ****************
	initial forever #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (valid === 1'b1) begin
			n_valid++;
			got = {kind, wide, mx};
		end
		if (nvp === 1'b1) n_nvp++;
	end
	function automatic logic [13:0] expect_cmd(input logic [7:0] op);
		cmd_kind_t k;
		case (op)
			8'h01: k = op_write_regs;
			8'h02, 8'h12: k = op_page_write;
			8'h03, 8'h13: k = op_plain_read;
			8'h05: k = op_read_status;
			8'h0b, 8'h0c: k = op_quick_read;
			8'h0d, 8'h0e: k = op_double_rate_read;
			8'h20, 8'h21: k = op_small_erase;
			8'h30: k = op_status_clear;
			8'h32, 8'h38: k = op_four_line_page_write;
			8'h35: k = op_read_config;
			8'h3b, 8'h3c: k = op_two_line_read;
			8'h41: k = op_training_read;
			8'h43: k = op_training_program;
			8'h4a: k = op_training_write;
			8'h6b: k = op_four_line_read;
			8'hf0: k = op_soft_reset;
			8'hff: k = op_escape;
			default: k = op_none;
		endcase
		if (k == op_none) return 14'h0000;
		return {k, op inside {8'h0c, 8'h0e, 8'h12, 8'h13, 8'h21, 8'h3c},
			k == op_plain_read ? 8'h32 : k inside {op_double_rate_read,
			op_four_line_page_write} ? 8'h50 : k inside {op_two_line_read,
			op_four_line_read} ? 8'h68 : 8'h85};
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge sys_clk);
		chk({15'h0000, busy}, 16'h0000);
	endtask
	task automatic send(input logic [7:0] op);
		int nv, np;
		logic [13:0] e;
		nv = n_valid;
		np = n_nvp;
		e = expect_cmd(op);
		u_host.frame(op);
		repeat (8) @(posedge sys_clk);
		chk(16'(n_valid - nv), 16'(e != 14'h0000));
		if (e != 14'h0000) chk({2'b00, got}, {2'b00, e});
		chk(16'(n_nvp - np), 16'(op == 8'h43));
		wait_idle();
	endtask
	task automatic wr_regs(input logic [7:0] s, input logic [7:0] c);
		st_wr <= s;
		cf_wr <= c;
		tr_wr <= 8'($urandom);
		regs_wr <= 1'b1;
		@(posedge sys_clk);
		regs_wr <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic soft_case(input logic vol, input logic frz);
		logic [7:0] s, c;
		int nv;
		s = 8'($urandom) | 8'h60;
		c = (8'($urandom) & 8'hf5) | {4'h0, vol, 1'b0, frz, 1'b0};
		send(8'h4a);
		@(posedge sys_clk);
		wr_regs(s, c);
		chk({8'h00, tr}, {8'h00, tr_wr});
		guard_set <= 1'b1;
		enter <= 1'b1;
		@(posedge sys_clk);
		guard_set <= 1'b0;
		enter <= 1'b0;
		repeat (4) @(posedge sys_clk);
		send(8'hff);
		chk({15'h0000, cont}, 16'h0000);
		u_host.frame(8'hf0);
		nv = n_valid;
		u_host.frame(8'h05);
		wait_idle();
		chk(16'(n_valid - nv), 16'h0000);
		chk({8'h00, st & 8'h7c}, {8'h00, vol && !frz ? 8'h00 : s & 8'h1c});
		chk({8'h00, cf}, {8'h00, frz ? c : c & 8'h2e});
		chk({7'h00, guard, tr}, {7'h00, 1'b1, training_reset_value});
		$display("soft reset case done");
	endtask
	task automatic results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		got = $urandom(32'h9f86da18);
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({guard, st, kind}, {1'b1, status_reset_value, op_none});
		foreach (ops[i]) send(ops[i]);
		$display("opcode table done");
		repeat (16) send(8'($urandom));
		$display("random opcodes done");
		@(posedge sys_clk);
		wr_regs(8'h60, 8'h00);
		send(8'h30);
		chk({8'h00, st & 8'h60}, 16'h0000);
		soft_case(1'b1, 1'b0);
		soft_case(1'b0, 1'b0);
		soft_case(1'b1, 1'b1);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({7'h00, guard, cf}, {7'h00, 1'b1, config_reset_value});
		$display("hard reset done");
		results();
	end
	initial begin
		#400000;
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
